// [include/oneshot_pkg.sv]
package oneshot_pkg;
  // Counter width per channel
  localparam int CNT_W = 32;
  // Reset values
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [31:0] CMP_RST = 32'h0000_0000;
  localparam logic OUT_IDLE = 1'b1;
  // Channel run states
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} run_state_t;
endpackage : oneshot_pkg

// [verilog/input_sampler.sv]
`timescale 1ns/1ps
// Registers one field input and reports its rising edge
module input_sampler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Field level
  input wire logic din,
  // Sampled level and edge
  output logic level,
  output logic rise
);
  logic q1_r, q1_nxt;
  logic q2_r, q2_nxt;

  // Two stages so the edge compares registered values only
  always_comb begin
    q1_nxt = din;
    q2_nxt = q1_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q1_r <= 1'b0;
      q2_r <= 1'b0;
    end else begin
      q1_r <= q1_nxt;
      q2_r <= q2_nxt;
    end
  end

  assign level = q1_r;
  assign rise = q1_r & ~q2_r;
endmodule : input_sampler

// [verilog/oneshot_down_counter_reset_out.sv]
`timescale 1ns/1ps
// Operation
// - One independent 32-bit down counter per channel.
// - During a run, decrement by one on each count-clock rising edge while gate high.
// - Clear input high empties counter; keep it low to count.
// - Active-low output goes low when the counter is loaded.
// - Output returns high when count reaches the compare value.
// - Stop command ends the counting run.
module oneshot_down_counter_reset_out
  import oneshot_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Field signals
  input wire logic count_clock_input,
  input wire logic gate_input,
  input wire logic count_clear_input,
  // Controller commands
  input wire logic compare_load,
  input wire logic [CNT_W-1:0] compare_value,
  input wire logic count_load,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic stop_cmd,
  // Status
  output logic [CNT_W-1:0] count_r,
  output logic out_n_r,
  output logic running_r
);
  logic clk_rise, gate_level, clr_level;
  logic [CNT_W-1:0] count_dec;
  logic [CNT_W-1:0] count_nxt, cmp_r, cmp_nxt;
  logic out_n_nxt, running_nxt;
  run_state_t state_r, state_nxt;
  logic step;

  // Field input sampling, one instance per input; unused edge and level outputs left open
  input_sampler u_clk (
    .clk(clk),
    .rst_n(rst_n),
    .din(count_clock_input),
    .level(),
    .rise(clk_rise)
  );
  input_sampler u_gate (
    .clk(clk),
    .rst_n(rst_n),
    .din(gate_input),
    .level(gate_level),
    .rise()
  );
  input_sampler u_clr (
    .clk(clk),
    .rst_n(rst_n),
    .din(count_clear_input),
    .level(clr_level),
    .rise()
  );

  // Counting keeps going after the compare match, as a one-shot output only
  assign step = clk_rise & gate_level;
  // Value the counter takes on a step; the match test looks at it before it is registered
  assign count_dec = count_r - 32'h0000_0001;

  // Compare register: written whenever the controller strobes it, even mid-run
  always_comb begin
    cmp_nxt = cmp_r;
    if (compare_load) begin
      cmp_nxt = compare_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_r <= CMP_RST;
    end else begin
      cmp_r <= cmp_nxt;
    end
  end

  // Next-state logic; clear outranks load and stepping
  always_comb begin
    count_nxt = count_r;
    out_n_nxt = out_n_r;
    state_nxt = state_r;
    case (state_r)
      ST_IDLE, ST_DONE: begin
        if (count_load) begin
          count_nxt = count_value;
          out_n_nxt = 1'b0;
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_cmd) begin
          state_nxt = ST_DONE;
          out_n_nxt = OUT_IDLE;
        end else if (count_load) begin
          count_nxt = count_value;
          out_n_nxt = 1'b0;
        end else if (step) begin
          count_nxt = count_dec;
          if (count_dec == cmp_r) begin
            out_n_nxt = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (clr_level) begin
      count_nxt = CNT_RST;
    end
  end

  assign running_nxt = (state_nxt == ST_RUN);

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= CNT_RST;
      out_n_r <= OUT_IDLE;
      state_r <= ST_IDLE;
      running_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      out_n_r <= out_n_nxt;
      state_r <= state_nxt;
      running_r <= running_nxt;
    end
  end

  // Checks: clear, load, stepping, gate hold, compare match, stop, idle hold and edge detection
  a_clear_empties: assert property (@(posedge clk) disable iff (!rst_n)
    clr_level |=> count_r == CNT_RST) else $error("clear did not empty counter");
  a_load_out_low: assert property (@(posedge clk) disable iff (!rst_n)
    (count_load && !stop_cmd && !clr_level) |=> !out_n_r) else $error("output not low");
  a_step_decrements: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_RUN && step && !count_load && !stop_cmd && !clr_level)
    |=> count_r == $past(count_r) - 32'h0000_0001) else $error("bad decrement");
  a_hold_no_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (!gate_level && !count_load && !clr_level) |=> count_r == $past(count_r))
    else $error("counted without gate");
  a_match_out_high: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_RUN && step && !count_load && !stop_cmd && !clr_level
     && count_r - 32'h0000_0001 == cmp_r) |=> out_n_r) else $error("no release at compare");
  a_stop_ends_run: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_RUN && stop_cmd) |=> !running_r && out_n_r) else $error("stop ignored");
  a_idle_no_count: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r != ST_RUN && !count_load && !clr_level) |=> $stable(count_r))
    else $error("counted while idle");
  a_edge_from_regs: assert property (@(posedge clk) disable iff (!rst_n)
    count_clock_input ##1 count_clock_input |=> !clk_rise) else $error("false edge");

  // Compare register follows its strobe and nothing else
  a_compare_capture: assert property (@(posedge clk) disable iff (!rst_n)
    compare_load |=> cmp_r == $past(compare_value))
    else $error("compare not captured");
  a_compare_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !compare_load |=> $stable(cmp_r))
    else $error("compare changed unasked");

  // Load: start value taken, run begins with the output pulled low
  a_load_value: assert property (@(posedge clk) disable iff (!rst_n)
    (count_load && !(state_r == ST_RUN && stop_cmd) && !clr_level)
    |=> count_r == $past(count_value)) else $error("start value not loaded");
  a_load_starts_run: assert property (@(posedge clk) disable iff (!rst_n)
    (count_load && !(state_r == ST_RUN && stop_cmd)) |=> running_r)
    else $error("load did not start run");
  a_run_out_low: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(running_r) |-> !out_n_r)
    else $error("run began with output high");
  a_reload_out_low: assert property (@(posedge clk) disable iff (!rst_n)
    (running_r && count_load && !stop_cmd) |=> running_r && !out_n_r)
    else $error("reload did not restart output");

  // Stepping: at most one count per cycle, and only on a registered edge
  a_single_step: assert property (@(posedge clk) disable iff (!rst_n)
    (!count_load && !clr_level)
    |=> (count_r == $past(count_r) || count_r == $past(count_r) - 32'h0000_0001))
    else $error("count moved by more than one");
  a_no_rise_no_step: assert property (@(posedge clk) disable iff (!rst_n)
    (!clk_rise && !count_load && !clr_level) |=> $stable(count_r))
    else $error("counted without an edge");

  // Output: released within a run only by a compare match, then held until reload or stop
  a_out_high_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (running_r && out_n_r && !count_load && !stop_cmd) |=> out_n_r)
    else $error("output fell without reload");
  a_no_early_release: assert property (@(posedge clk) disable iff (!rst_n)
    (running_r && !out_n_r && !stop_cmd && !(step && count_dec == cmp_r)) |=> !out_n_r)
    else $error("output released before compare");
  a_release_by_step: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(out_n_r) && running_r) |-> $past(step))
    else $error("output released without a step");

  // Run state: ended by stop only, with the output left high
  a_idle_out_high: assert property (@(posedge clk) disable iff (!rst_n)
    !running_r |-> out_n_r)
    else $error("output low outside a run");
  a_stop_outside_run: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r != ST_RUN && stop_cmd && !count_load) |=> !running_r)
    else $error("stray stop started a run");
  a_run_ends_by_stop: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(running_r) |-> $past(stop_cmd))
    else $error("run ended without stop");

  // Clear touches the count only, never the run or the output
  a_clear_keeps_run: assert property (@(posedge clk) disable iff (!rst_n)
    (clr_level && !count_load && !stop_cmd) |=> $stable(running_r))
    else $error("clear changed run state");
  a_clear_keeps_out: assert property (@(posedge clk) disable iff (!rst_n)
    (clr_level && !count_load && !stop_cmd && !step) |=> $stable(out_n_r))
    else $error("clear changed output");

  // Main scenarios
  c_load_run: cover property (@(posedge clk) disable iff (!rst_n) count_load ##1 running_r);
  c_match: cover property (@(posedge clk) disable iff (!rst_n) !out_n_r ##1 out_n_r);
  c_stop: cover property (@(posedge clk) disable iff (!rst_n) running_r ##1 stop_cmd);
  c_reload_run: cover property (@(posedge clk) disable iff (!rst_n) running_r && count_load);
  c_clear_run: cover property (@(posedge clk) disable iff (!rst_n) running_r && clr_level);
endmodule : oneshot_down_counter_reset_out

// [tb/field_clock_model.sv]
`timescale 1ns/1ps
// Field side: count clock bursts, resting low between them
module field_clock_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Burst enable
  input wire logic en,
  // Field count clock
  output logic count_clock_input
);
  // One cycle high, one low: the shortest phase the counter accepts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) count_clock_input <= 1'b0;
    else count_clock_input <= en & ~count_clock_input;
  end
endmodule : field_clock_model

// [tb/oneshot_down_counter_reset_out_tb_top.sv]
`timescale 1ns/1ps
module oneshot_down_counter_reset_out_tb_top;
  import oneshot_pkg::*;
  logic clk, rst_n, cci, gate, clr, cl, ld, stop, en, out_n, run;
  logic [CNT_W-1:0] cv, lv, cnt, s, c;
  int fails, n_tests, n;
  field_clock_model mdl_u (.clk(clk), .rst_n(rst_n), .en(en), .count_clock_input(cci));
  oneshot_down_counter_reset_out dut_u (.clk(clk), .rst_n(rst_n), .count_clock_input(cci),
    .gate_input(gate), .count_clear_input(clr), .compare_load(cl), .compare_value(cv),
    .count_load(ld), .count_value(lv), .stop_cmd(stop), .count_r(cnt), .out_n_r(out_n),
    .running_r(run));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Output goes back high only if the compare value was passed on the way down
  function logic exp_out(input logic [31:0] st, input logic [31:0] cm, input int k);
    return (cm < st) && (cm >= st - 32'(k));
  endfunction : exp_out
  task run_once(input logic [31:0] st, input logic [31:0] cm, input int k, input logic g,
    input logic rl);
    @(posedge clk) begin
      cl <= 1'b1;
      cv <= cm;
      gate <= g;
    end
    @(posedge clk) begin
      cl <= 1'b0;
      ld <= 1'b1;
      lv <= st;
    end
    @(posedge clk) ld <= 1'b0;
    #1 chk("load out", {31'h0, out_n}, 32'h0);
    chk("load cnt", cnt, st);
    chk("load run", {31'h0, run}, 32'h1);
    @(posedge clk) en <= 1'b1;
    repeat (2 * k) @(posedge clk);
    en <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("count", cnt, g ? st - 32'(k) : st);
    chk("match out", {31'h0, out_n}, {31'h0, g & exp_out(st, cm, k)});
    // Reload mid-run restarts the count and pulls the output low again
    if (rl) begin
      @(posedge clk) begin
        ld <= 1'b1;
        lv <= st;
      end
      @(posedge clk) ld <= 1'b0;
      #1 chk("reload cnt", cnt, st);
      chk("reload out", {31'h0, out_n}, 32'h0);
    end
    @(posedge clk) stop <= 1'b1;
    @(posedge clk) stop <= 1'b0;
    #1 chk("stop run", {31'h0, run}, 32'h0);
    chk("stop out", {31'h0, out_n}, 32'h1);
    $display("test done start %h cmp %h steps %0d", st, cm, k);
  endtask : run_once
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    {rst_n, gate, clr, cl, ld, stop, en} = 7'h00;
    cv = 32'h0;
    lv = 32'h0;
    fails = 0;
    n_tests = 0;
    void'($urandom(51));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("rst out", {31'h0, out_n}, 32'h1);
    run_once(32'h20, 32'h1D, 3, 1'b1, 1'b1); // Lands on compare at last step, then reload
    run_once(32'h20, 32'h1C, 3, 1'b1, 1'b0); // Stops one short of compare
    run_once(32'h20, 32'h1F, 3, 1'b0, 1'b0); // Gate low holds count
    for (int i = 0; i < 6; i++) begin
      s = 32'h100 + $urandom_range(0, 32'hFFFF);
      c = s - $urandom_range(1, 12);
      n = $urandom_range(1, 10);
      run_once(s, c, n, 1'b1, 1'($urandom_range(0, 1)));
    end
    // Clear in mid-run: count emptied, output and run untouched
    @(posedge clk) begin
      ld <= 1'b1;
      lv <= 32'h77;
    end
    @(posedge clk) begin
      ld <= 1'b0;
      clr <= 1'b1;
    end
    repeat (3) @(posedge clk);
    #1 chk("clear", cnt, 32'h0);
    chk("clear out", {31'h0, out_n}, 32'h0);
    chk("clear run", {31'h0, run}, 32'h1);
    @(posedge clk) clr <= 1'b0;
    $display("test done clear");
    // Reset in mid-run returns the outputs to idle
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    #1 chk("reset run", {31'h0, run}, 32'h0);
    chk("reset out", {31'h0, out_n}, 32'h1);
    $display("test done reset");
    print_verdict();
  end
endmodule : oneshot_down_counter_reset_out_tb_top
